// [logic/lcd_ctrl.sv]
// segment lcd frame timing, bias control and display buffer scan
`timescale 1ns/100ps
`include "lcd_regs.svh"
module lcd_ctrl #(
  parameter int NUM_SEG = 40,
  parameter int BUF_N = `BUF_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic low_speed_clock,
  input wire logic stop_req,
  output logic [7:0] common_output,
  output logic [2*NUM_SEG-1:0] segment_output,
  output logic [NUM_SEG-1:0] segment_oe_n,
  output logic supply_switch,
  output logic tap_bleeder_mode,
  output logic internal_ladder_en,
  output logic low_switch,
  output logic high_res_sel
);

  // ========================================================================
  // control registers
  logic driver_enable_r;
  logic [3:0] base_freq_select_r;
  lcd_pkg::drive_t duty_r;
  logic display_on_r;
  logic bleeder_source_select_r;
  logic high_res_r;
  logic [2:0] low_resistor_on_time_r;
  logic [7:0] buf_r [BUF_N];
  logic buf_hit;
  logic [7:0] buf_ofs;
  logic [4:0] buf_idx;
  localparam logic [7:0] CTRL1_RST_V = `CTRL1_RST;
  localparam logic [7:0] CTRL2_RST_V = `CTRL2_RST;

  assign buf_ofs = 8'(addr - `OFS_BUF_BASE);
  assign buf_idx = buf_ofs[6:2];
  assign buf_hit = (addr >= `OFS_BUF_BASE) && (buf_ofs < 8'(4 * BUF_N)) && (addr[1:0] == 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      driver_enable_r <= `EN_RST;
    end else if (wr && addr == `OFS_ENABLE) begin
      driver_enable_r <= wdata[`EN_DRV_BIT];
    end
  end

  // stop entry outranks a display-on write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      base_freq_select_r <= CTRL1_RST_V[`CTRL1_SLF_LSB +: 4];
      duty_r <= lcd_pkg::DRV_QUARTER;
      display_on_r <= 1'b0;
    end else begin
      if (wr && addr == `OFS_CTRL1) begin
        base_freq_select_r <= wdata[`CTRL1_SLF_LSB +: 4];
        duty_r <= lcd_pkg::drive_t'(wdata[`CTRL1_DUTY_LSB +: 3]);
        display_on_r <= wdata[`CTRL1_DSP_BIT];
      end
      if (stop_req) begin
        display_on_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bleeder_source_select_r <= CTRL2_RST_V[`CTRL2_BLEEDER_SOURCE_SELECT_BIT];
      high_res_r <= CTRL2_RST_V[`CTRL2_BRH_BIT];
      low_resistor_on_time_r <= CTRL2_RST_V[`CTRL2_LOW_RESISTOR_ON_TIME_LSB +: 3];
    end else if (wr && addr == `OFS_CTRL2) begin
      bleeder_source_select_r <= wdata[`CTRL2_BLEEDER_SOURCE_SELECT_BIT];
      high_res_r <= wdata[`CTRL2_BRH_BIT];
      low_resistor_on_time_r <= wdata[`CTRL2_LOW_RESISTOR_ON_TIME_LSB +: 3];
    end
  end

  // every bit is kept, used by the scan or not
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < BUF_N; i++) begin
        buf_r[i] <= `BUF_RST;
      end
    end else if (wr && buf_hit) begin
      buf_r[buf_idx] <= wdata[7:0];
    end
  end

  // ========================================================================
  // base frequency prescalers
  logic ls_d_r;
  logic fine_tick;
  logic gear_sel;
  logic ls_sel;
  div_if gear_if ();
  div_if ls_if ();

  always_ff @(posedge clk) begin
    if (rst) begin
      ls_d_r <= 1'b0;
    end else begin
      ls_d_r <= low_speed_clock;
    end
  end

  assign gear_sel = base_freq_select_r <= `SLF_GEAR_LAST;
  assign ls_sel = (base_freq_select_r == `SLF_LS_DIV9) || (base_freq_select_r == `SLF_LS_DIV8);
  assign gear_if.src_tick = 1'b1;
  // fine tick runs 2^FINE_SHIFT times faster than the base frequency
  assign gear_if.exponent = 4'(`GEAR_FINE_EXP - base_freq_select_r);
  assign ls_if.src_tick = low_speed_clock & ~ls_d_r;
  assign ls_if.exponent = 4'(`LS_FINE_EXP - {3'h0, base_freq_select_r[0]});
  // reserved codes stop the scan rather than guess a rate
  assign fine_tick = (gear_sel && gear_if.tick) || (ls_sel && ls_if.tick);

  base_divider #(.CNT_W(13)) u_gear_div (.clk(clk), .rst(rst), .port(gear_if.div));
  base_divider #(.CNT_W(13)) u_ls_div (.clk(clk), .rst(rst), .port(ls_if.div));

  // ========================================================================
  // frame counter: quarter phases of eight fine ticks each
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [4:0] frame_last;
  logic [2:0] quarters;
  logic pol_r;
  logic [1:0] phase_r;
  logic [1:0] next_phase;
  logic phase_start;
  logic is_static;
  logic third_bias;

  assign is_static = duty_r == lcd_pkg::DRV_STATIC;
  assign third_bias = (duty_r == lcd_pkg::DRV_QUARTER) || (duty_r == lcd_pkg::DRV_THIRD_B3);

  always_comb begin
    case (duty_r)
      lcd_pkg::DRV_THIRD_B3: quarters = 3'h3;
      lcd_pkg::DRV_THIRD_B2: quarters = 3'h3;
      lcd_pkg::DRV_HALF: quarters = 3'h2;
      default: quarters = 3'h4;
    endcase
  end

  assign frame_last = 5'({quarters, 3'h0} - 6'h01);
  assign cnt_nxt = (cnt_r >= frame_last) ? 5'h00 : 5'(cnt_r + 5'h01);
  assign next_phase = is_static ? 2'h0 : cnt_nxt[4:3];
  assign phase_start = fine_tick && (cnt_nxt[`SUB_BITS-1:0] == 3'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 5'h00;
      pol_r <= 1'b0;
    end else if (fine_tick) begin
      cnt_r <= cnt_nxt;
      if (cnt_nxt == 5'h00) begin
        pol_r <= ~pol_r; // frame inversion keeps the glass free of dc
      end
    end
  end

  // ========================================================================
  // buffer sampling at phase start, low nibble even segment
  logic [NUM_SEG-1:0] seg_on_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 2'h0;
      seg_on_r <= '0;
    end else if (phase_start) begin
      phase_r <= next_phase;
      for (int s = 0; s < NUM_SEG; s++) begin
        seg_on_r[s] <= buf_r[s >> 1][((s & 1) * 4) + int'(next_phase)];
      end
    end
  end

  // ========================================================================
  // pin drivers
  logic active;
  logic lr_window;

  assign active = display_on_r && driver_enable_r;
  assign lr_window = cnt_r[`SUB_BITS-1:0] < low_resistor_on_time_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      common_output <= 8'h00;
      segment_output <= '0;
    end else if (!active) begin
      common_output <= 8'h00;
      segment_output <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (c == int'(phase_r)) begin
          common_output[2*c +: 2] <= pol_r ? 2'h3 : 2'h0;
        end else if (third_bias) begin
          common_output[2*c +: 2] <= pol_r ? 2'h1 : 2'h2;
        end else begin
          common_output[2*c +: 2] <= 2'h1;
        end
      end
      for (int s = 0; s < NUM_SEG; s++) begin
        if (seg_on_r[s]) begin
          segment_output[2*s +: 2] <= pol_r ? 2'h0 : 2'h3;
        end else if (third_bias) begin
          segment_output[2*s +: 2] <= pol_r ? 2'h2 : 2'h1;
        end else begin
          segment_output[2*s +: 2] <= pol_r ? 2'h3 : 2'h0;
        end
      end
    end
  end

  // tap-shared segments give way to the external ladder
  always_ff @(posedge clk) begin
    if (rst) begin
      segment_oe_n <= '1;
    end else begin
      for (int s = 0; s < NUM_SEG; s++) begin
        segment_oe_n[s] <= !bleeder_source_select_r && (s >= NUM_SEG - `TAP_SEG_COUNT);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      supply_switch <= 1'b0;
      tap_bleeder_mode <= 1'b1;
      internal_ladder_en <= 1'b0;
      low_switch <= 1'b0;
      high_res_sel <= 1'b0;
    end else begin
      supply_switch <= display_on_r;
      tap_bleeder_mode <= !bleeder_source_select_r;
      internal_ladder_en <= bleeder_source_select_r && active;
      low_switch <= active && bleeder_source_select_r && lr_window;
      high_res_sel <= high_res_r;
    end
  end

  // ========================================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      if (addr == `OFS_ENABLE) begin
        rdata <= {31'h0, driver_enable_r};
      end else if (addr == `OFS_CTRL1) begin
        rdata <= {24'h0, display_on_r, duty_r, base_freq_select_r};
      end else if (addr == `OFS_CTRL2) begin
        rdata <= {27'h0, low_resistor_on_time_r, high_res_r, bleeder_source_select_r};
      end else if (addr == `OFS_STATUS) begin
        rdata <= {27'h0, pol_r, phase_r, low_switch, active};
      end else if (buf_hit) begin
        rdata <= {24'h0, buf_r[buf_idx]};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // checks
  logic [13:0] gap_r;
  // skips the first two ticks after a rate change, the first may still follow the old mask
  logic [1:0] gap_seen_r;
  logic [4:0] fticks_r;
  logic frame_seen_r;

  always_ff @(posedge clk) begin
    if (rst || (wr && addr == `OFS_CTRL1)) begin
      gap_r <= 14'h0000;
      gap_seen_r <= 2'h0;
      fticks_r <= 5'h00;
      frame_seen_r <= 1'b0;
    end else begin
      gap_r <= gear_if.tick ? 14'h0000 : 14'(gap_r + 14'h0001);
      gap_seen_r <= (gear_if.tick && gap_seen_r != 2'h2) ? 2'(gap_seen_r + 2'h1) : gap_seen_r;
      if (fine_tick) begin
        fticks_r <= (cnt_nxt == 5'h00) ? 5'h00 : 5'(fticks_r + 5'h01);
        frame_seen_r <= frame_seen_r || (cnt_nxt == 5'h00);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_ctrl2;
    wr && addr == `OFS_CTRL2;
  endsequence

  sequence s_drv_off;
    wr && addr == `OFS_ENABLE && !wdata[`EN_DRV_BIT];
  endsequence

  sequence s_dark;
    common_output == 8'h00 && segment_output == '0;
  endsequence

  a_gear_period: assert property (gear_sel && gear_if.tick && gap_seen_r == 2'h2
      |-> gap_r == 14'((14'h0001 << gear_if.exponent) - 14'h0001))
    else $error("gear prescaler period wrong");

  a_frame_length: assert property (fine_tick && cnt_nxt == 5'h00 && frame_seen_r
      |-> fticks_r == frame_last)
    else $error("frame length does not match drive method");

  a_tap_mode: assert property (s_wr_ctrl2 |-> ##2
      tap_bleeder_mode == !$past(wdata[`CTRL2_BLEEDER_SOURCE_SELECT_BIT], 2))
    else $error("tap pin mode does not follow bleeder select");

  a_low_switch: assert property (low_switch |-> $past(bleeder_source_select_r) && $past(lr_window))
    else $error("low switch closed outside its window");

  a_pixel_on: assert property ($past(active) && $past(seg_on_r[0]) && !$past(rst)
      |-> segment_output[1:0] == ($past(pol_r) ? 2'h0 : 2'h3))
    else $error("lit pixel not driven against common");

  a_buffer_clear: assert property ($fell(rst) |-> buf_r[0] == 8'h00 && buf_r[BUF_N-1] == 8'h00)
    else $error("buffer not cleared by reset");

  a_reset_pins: assert property (disable iff (1'b0) rst
      |=> segment_oe_n == '1 && common_output == 8'h00 && tap_bleeder_mode)
    else $error("pins not in reset state");

  a_stop_blank: assert property (stop_req |-> ##2 common_output == 8'h00)
    else $error("stop did not blank the display");

  a_drv_blank: assert property (s_drv_off ##1 !wr |=> s_dark)
    else $error("driver disable did not blank");

endmodule // lcd_ctrl

// [shared/lcd_regs.svh]
// register offsets, field positions, reset values and divider exponents of the lcd block
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH

// ==========================================================================
// register offsets (byte addresses on the register port)
`define OFS_ENABLE 8'h00
`define OFS_CTRL1 8'h04
`define OFS_CTRL2 8'h08
`define OFS_STATUS 8'h0C
`define OFS_BUF_BASE 8'h40
`define BUF_COUNT 20

// ==========================================================================
// field positions
`define EN_DRV_BIT 0
`define CTRL1_SLF_LSB 0
`define CTRL1_DUTY_LSB 4
`define CTRL1_DSP_BIT 7
`define CTRL2_BLEEDER_SOURCE_SELECT_BIT 0
`define CTRL2_BRH_BIT 1
`define CTRL2_LOW_RESISTOR_ON_TIME_LSB 2

// ==========================================================================
// reset values
`define EN_RST 1'h0
`define CTRL1_RST 8'h00
`define CTRL2_RST 8'h00
`define BUF_RST 8'h00

// ==========================================================================
// base frequency codes and divider exponents
`define SLF_GEAR_LAST 4'h4
`define SLF_LS_DIV9 4'h8
`define SLF_LS_DIV8 4'h9
`define GEAR_EXP_TOP 18
`define LS_EXP_TOP 9
`define FINE_SHIFT 5
`define GEAR_FINE_EXP 4'hD
`define LS_FINE_EXP 4'h4
`define SUB_BITS 3
`define TAP_SEG_COUNT 2

`endif

// [shared/lcd_pkg.sv]
// types shared by the lcd frame and data control block
package lcd_pkg;

  // ========================================================================
  // drive method, in field order
  typedef enum logic [2:0] {
    DRV_QUARTER,
    DRV_THIRD_B3,
    DRV_THIRD_B2,
    DRV_HALF,
    DRV_STATIC
  } drive_t;

  // level index: 0 ground, 1 lower tap, 2 upper tap, 3 drive supply
  typedef logic [1:0] level_t;

endpackage

// [shared/div_if.sv]
// carrier between the frame controller and one prescaler
`timescale 1ns/100ps
interface div_if;
  logic src_tick;
  logic [3:0] exponent;
  logic tick;

  modport ctrl (output src_tick, output exponent, input tick);
  modport div (input src_tick, input exponent, output tick);
endinterface

// [logic/base_divider.sv]
// power-of-two prescaler producing one fine tick per 2^exponent source ticks
`timescale 1ns/100ps
module base_divider #(
  parameter int CNT_W = 13
) (
  input wire logic clk,
  input wire logic rst,
  div_if.div port
);

  // ========================================================================
  // counter
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mask;

  assign mask = CNT_W'((CNT_W'(1) << port.exponent) - CNT_W'(1));

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (port.src_tick) begin
      cnt_r <= CNT_W'(cnt_r + CNT_W'(1));
    end
  end

  // ========================================================================
  // tick, registered so the consumer sees a clean one-cycle pulse
  logic tick_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= port.src_tick && ((cnt_r & mask) == mask);
    end
  end

  assign port.tick = tick_r;

endmodule // base_divider

// [test/lcd_glass.sv]
// passive segment lcd glass: a pixel lights when its two electrodes sit at opposite rails
`timescale 1ns/100ps
module lcd_glass (
  input wire logic [7:0] common_output,
  input wire logic [79:0] segment_output,
  input wire logic [39:0] segment_oe_n,
  input wire logic supply_switch,
  output logic [159:0] lit
);
  // ==========================================================================
  // pixel voltage
  // a floating segment pin never lights anything, whatever level it last showed
  always_comb begin
    for (int s = 0; s < 40; s++) begin
      for (int c = 0; c < 4; c++) begin
        lit[4*s+c] = supply_switch === 1'b1 && segment_oe_n[s] === 1'b0 &&
          ((common_output[2*c+:2] === 2'h3 && segment_output[2*s+:2] === 2'h0) ||
           (common_output[2*c+:2] === 2'h0 && segment_output[2*s+:2] === 2'h3));
      end
    end
  end
endmodule // lcd_glass

// [test/testbench.sv]
// self-checking bench for the lcd frame and data control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic clk, rst, wr, rd, ls, stop_req, acc_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] common_output;
  logic [79:0] segment_output;
  logic [39:0] segment_oe_n;
  logic supply_switch, tap_bleeder_mode, internal_ladder_en, low_switch, high_res_sel;
  logic [159:0] lit, acc;
  logic [7:0] bufv [20];
  logic [2:0] lt_tab [5] = '{3'h0, 3'h3, 3'h7, 3'h5, 3'h1};
  int num_errors = 0;
  int checked = 0;
  int seed = 54;
  int cycles = 0;
  int n, lo, nc;

  lcd_ctrl dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .low_speed_clock(ls), .stop_req(stop_req), .common_output(common_output),
    .segment_output(segment_output), .segment_oe_n(segment_oe_n),
    .supply_switch(supply_switch), .tap_bleeder_mode(tap_bleeder_mode),
    .internal_ladder_en(internal_ladder_en), .low_switch(low_switch),
    .high_res_sel(high_res_sel));
  lcd_glass glass_u (.common_output(common_output), .segment_output(segment_output),
    .segment_oe_n(segment_oe_n), .supply_switch(supply_switch), .lit(lit));

  // ==========================================================================
  // clock, slow clock, timeout
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // slow clock rises every second cycle: one fine tick per 16 or 32 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    ls <= ~ls;
    if (acc_en) acc <= acc | lit;
    if (cycles == 100000) begin
      num_errors++;
      finish_test();
    end
  end

  // ==========================================================================
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  task automatic fill();
    for (int i = 0; i < 20; i++) begin
      bufv[i] = 8'($random(seed));
      wr_reg(8'h40 + 8'(4 * i), {24'h0, bufv[i]});
    end
  endtask
  // cycles and low-switch cycles from one rise of common 0 to the rail to the next
  task automatic next_rise(output int cnt, output int low);
    logic prev;
    cnt = 0;
    low = 0;
    prev = 1'b1;
    while (cnt < 40000) begin
      @(posedge clk);
      #1 cnt++;
      if (low_switch === 1'b1) low++;
      if (!prev && common_output[1:0] === 2'h3) break;
      prev = (common_output[1:0] === 2'h3);
    end
  endtask
  function automatic int ncom(input int d);
    return (d == 0) ? 4 : (d == 3) ? 2 : (d == 4) ? 1 : 3;
  endfunction
  function automatic logic [159:0] exp_pix(input int d);
    exp_pix = '0;
    for (int s = 0; s < 40; s++) begin
      for (int c = 0; c < ncom(d); c++) exp_pix[4*s+c] = bufv[s/2][4*(s%2)+c];
    end
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1;
    wr = 0;
    rd = 0;
    addr = 0;
    wdata = 0;
    ls = 0;
    stop_req = 0;
    acc = 0;
    acc_en = 0;
    repeat (4) @(posedge clk);
    #1 `CHK("commons", 8'h00, common_output)
    `CHK("seg oe", {40{1'b1}}, segment_oe_n)
    `CHK("bleeder", 1'b1, tap_bleeder_mode)
    rst <= 1'b0;
    for (int i = 0; i < 20; i++) rd_chk(8'h40 + 8'(4 * i), 32'h0, "buf rst");
    rd_chk(8'h04, 32'h0, "ctrl1 rst");
    rd_chk(8'hA0, 32'h0, "unmapped");
    fill();
    for (int i = 0; i < 20; i++) rd_chk(8'h40 + 8'(4 * i), {24'h0, bufv[i]}, "buf");
    $display("test registers done");
    wr_reg(8'h00, 32'h1);
    for (int d = 0; d < 5; d++) begin
      nc = ncom(d);
      wr_reg(8'h08, {27'h0, lt_tab[d], d[0], 1'b1});
      wr_reg(8'h04, 32'h80 | (d << 4) | 32'h9);
      fill();
      // two phases, so the fresh buffer is sampled in every drive method
      repeat (256) @(posedge clk);
      #1 acc = '0;
      acc_en = 1;
      repeat (nc * 256) @(posedge clk);
      #1 acc_en = 0;
      `CHK("pixels", exp_pix(d), acc)
      `CHK("supply", 1'b1, supply_switch)
      `CHK("ladder", 1'b1, internal_ladder_en)
      `CHK("tap mode", 1'b0, tap_bleeder_mode)
      `CHK("high res", d[0], high_res_sel)
      next_rise(n, lo);
      next_rise(n, lo);
      // static still runs four phases per frame
      `CHK("period", ((d == 4) ? 4 : nc) * 256, n)
      `CHK("low time", int'(lt_tab[d]) * 32 * ((d == 4) ? 4 : nc), lo)
    end
    $display("test scan done");
    wr_reg(8'h04, 32'h88);
    next_rise(n, lo);
    next_rise(n, lo);
    `CHK("period div9", 2048, n)
    // fastest gear rate at half duty keeps the run short
    wr_reg(8'h04, 32'hB4);
    next_rise(n, lo);
    next_rise(n, lo);
    `CHK("period gear", 16384, n)
    wr_reg(8'h04, 32'h89);
    $display("test rates done");
    wr_reg(8'h08, 32'h1C);
    repeat (4) @(posedge clk);
    #1 `CHK("tap mode ext", 1'b1, tap_bleeder_mode)
    `CHK("tap seg oe", 2'b11, segment_oe_n[39:38])
    `CHK("other seg oe", 38'h0, segment_oe_n[37:0])
    `CHK("low sw ext", 1'b0, low_switch)
    wr_reg(8'h00, 32'h0);
    repeat (4) @(posedge clk);
    #1 `CHK("dark com", 8'h00, common_output)
    `CHK("dark seg", 80'h0, segment_output)
    wr_reg(8'h00, 32'h1);
    next_rise(n, lo);
    `CHK("restored", 2'h3, common_output[1:0])
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("stop supply", 1'b0, supply_switch)
    `CHK("stop com", 8'h00, common_output)
    rd_chk(8'h04, 32'h09, "stop ctrl1");
    $display("test blanking done");
    finish_test();
  end
endmodule // testbench
